// *** hw/uswp_pkg.sv ***
package uswp_pkg;
    // =========================================
    // register map
    localparam logic [31:0] POWER_CTL_OFFSET = 32'h0000_0000;
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;

    // =========================================
    // field positions inside the power control register
    localparam int WAKE_EN_BIT = 7;
    localparam int REMOTE_WAKE_BIT = 6;
    localparam int PHY_RESETB_BIT = 5;
    localparam int SUSPEND_STAT_BIT = 4;

    // =========================================
    // reset values
    localparam logic WAKE_EN_RESET = 1'b0;
    localparam logic REMOTE_WAKE_RESET = 1'b0;
    localparam logic PHY_RESETB_RESET = 1'b1;

    // =========================================
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // =========================================
    // synchroniser depth
    localparam int SYNC_STAGES = 2;
endpackage

// *** hw/uswp_reg_if.sv ***
interface uswp_reg_if;
    logic wr_en;
    logic [uswp_pkg::ADDR_WIDTH-1:0] wr_addr;
    logic [uswp_pkg::DATA_WIDTH-1:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic [uswp_pkg::ADDR_WIDTH-1:0] rd_addr;
    logic [uswp_pkg::DATA_WIDTH-1:0] rd_data;
    logic rd_hit;

    modport bus (
        output wr_en,
        output wr_addr,
        output wr_data,
        output wr_strb,
        input wr_hit,
        output rd_addr,
        input rd_data,
        input rd_hit
    );
    modport regs (
        input wr_en,
        input wr_addr,
        input wr_data,
        input wr_strb,
        output wr_hit,
        input rd_addr,
        output rd_data,
        output rd_hit
    );
endinterface

// *** hw/uswp_sync.sv ***
module uswp_sync (
    input wire logic clock,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    // first stage is read only by the second one
    logic [uswp_pkg::SYNC_STAGES-1:0] stages;
    logic [uswp_pkg::SYNC_STAGES-1:0] next_stages;

    always_comb begin
        next_stages = {stages[uswp_pkg::SYNC_STAGES-2:0], async_in};
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            stages <= '0;
        end else begin
            stages <= next_stages;
        end
    end

    assign sync_out = stages[uswp_pkg::SYNC_STAGES-1];
endmodule // uswp_sync

// *** hw/uswp_axil_slave.sv ***
module uswp_axil_slave (
    input wire logic clock,
    input wire logic rst,
    input wire logic [uswp_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [uswp_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    uswp_reg_if.bus regs
);
    // =========================================
    // write channel: address and data accepted in either order
    logic aw_have, next_aw_have;
    logic w_have, next_w_have;
    logic [uswp_pkg::ADDR_WIDTH-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;

    assign s_axi_awready = !aw_have && !bvalid;
    assign s_axi_wready = !w_have && !bvalid;
    assign regs.wr_en = aw_have && w_have && !bvalid;
    assign regs.wr_addr = aw_addr;
    assign regs.wr_data = w_data;
    assign regs.wr_strb = w_strb;

    always_comb begin
        next_aw_have = aw_have;
        next_w_have = w_have;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_have = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_have = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (regs.wr_en) begin
            next_aw_have = 1'b0;
            next_w_have = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = regs.wr_hit ? uswp_pkg::RESP_OKAY : uswp_pkg::RESP_DECERR;
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= uswp_pkg::RESP_OKAY;
        end else begin
            aw_have <= next_aw_have;
            w_have <= next_w_have;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;

    // =========================================
    // read channel: data sampled at the address handshake
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;

    assign s_axi_arready = !rvalid;
    assign regs.rd_addr = s_axi_araddr;

    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata = regs.rd_hit ? regs.rd_data : 32'h0000_0000;
            next_rresp = regs.rd_hit ? uswp_pkg::RESP_OKAY : uswp_pkg::RESP_DECERR;
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= uswp_pkg::RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
endmodule // uswp_axil_slave

// *** hw/uswp_power_ctl.sv ***
// Functional notes
// - wake enable set: wake output goes low asynchronously when suspend ends
// - wake enable clear: wake output never asserted
// - remote wake bit at one drives core wakeup input high
// - remote wake write of one ignored while core is not suspended
// - remote wake bit clears itself once the core leaves suspend
// - phy reset bit at zero drives phy reset high, one releases it
// - phy reset bit is never released by hardware; software writes one
// - suspend status reads zero while suspended, one otherwise
module uswp_power_ctl (
    input wire logic clock,
    input wire logic rst,
    input wire logic [uswp_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [uswp_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic core_suspend_n,
    output logic core_remote_wake_in,
    output logic phy_reset_out,
    output logic usb_wake_irq_n
);
    // =========================================
    // bus slave
    uswp_reg_if regs ();

    uswp_axil_slave u_slave (
        .clock(clock),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .regs(regs.bus)
    );

    // =========================================
    // suspend status from the core domain
    logic suspend_n_sync;

    uswp_sync u_sync (
        .clock(clock),
        .rst(rst),
        .async_in(core_suspend_n),
        .sync_out(suspend_n_sync)
    );

    // =========================================
    // register decode
    logic wr_sel;
    logic lane0;

    assign regs.wr_hit = regs.wr_addr == uswp_pkg::POWER_CTL_OFFSET[uswp_pkg::ADDR_WIDTH-1:0];
    assign regs.rd_hit = regs.rd_addr == uswp_pkg::POWER_CTL_OFFSET[uswp_pkg::ADDR_WIDTH-1:0];
    // upper lanes carry only read-as-zero bits
    assign lane0 = regs.wr_strb[0];
    assign wr_sel = regs.wr_en && regs.wr_hit && lane0;

    // =========================================
    // control bits
    logic wake_en, next_wake_en;
    logic remote_wake, next_remote_wake;
    logic phy_reset_q, next_phy_reset_q;

    always_comb begin
        next_wake_en = wake_en;
        next_remote_wake = remote_wake;
        next_phy_reset_q = phy_reset_q;
        if (wr_sel) begin
            next_wake_en = regs.wr_data[uswp_pkg::WAKE_EN_BIT];
            // held only by software writes, never self-released
            next_phy_reset_q = !regs.wr_data[uswp_pkg::PHY_RESETB_BIT];
        end
        // writing zero is no operation; one only takes while suspended
        if (wr_sel && regs.wr_data[uswp_pkg::REMOTE_WAKE_BIT] && !suspend_n_sync) begin
            next_remote_wake = 1'b1;
        end
        if (suspend_n_sync) begin
            next_remote_wake = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wake_en <= uswp_pkg::WAKE_EN_RESET;
            remote_wake <= uswp_pkg::REMOTE_WAKE_RESET;
            phy_reset_q <= !uswp_pkg::PHY_RESETB_RESET;
        end else begin
            wake_en <= next_wake_en;
            remote_wake <= next_remote_wake;
            phy_reset_q <= next_phy_reset_q;
        end
    end

    // =========================================
    // outputs
    assign core_remote_wake_in = remote_wake;
    assign phy_reset_out = phy_reset_q;
    // raw pin on purpose: the fast clock may be stopped while waiting to wake
    assign usb_wake_irq_n = !(wake_en && core_suspend_n);

    // =========================================
    // read back
    always_comb begin
        regs.rd_data = 32'h0000_0000;
        regs.rd_data[uswp_pkg::WAKE_EN_BIT] = wake_en;
        regs.rd_data[uswp_pkg::REMOTE_WAKE_BIT] = remote_wake;
        regs.rd_data[uswp_pkg::PHY_RESETB_BIT] = !phy_reset_q;
        regs.rd_data[uswp_pkg::SUSPEND_STAT_BIT] = suspend_n_sync;
    end
endmodule // uswp_power_ctl

// *** dv/uswp_props.sv ***
module uswp_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic core_suspend_n,
    input wire logic core_remote_wake_in,
    input wire logic phy_reset_out,
    input wire logic usb_wake_irq_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // properties
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_irq_when_awake: assert property (!usb_wake_irq_n |-> core_suspend_n)
        else $error("wake out while suspended");
    a_rwake_clears: assert property (core_suspend_n [*4] |-> !core_remote_wake_in)
        else $error("remote wake kept");
    a_rwake_suspended: assert property ($rose(core_remote_wake_in) |-> !$past(core_suspend_n, 3))
        else $error("remote wake set awake");
    a_rwake_by_write: assert property ($rose(core_remote_wake_in) |-> $rose(s_axi_bvalid))
        else $error("remote wake without write");
    a_rwake_drop_late: assert property ($fell(core_remote_wake_in) |-> $past(core_suspend_n, 3) || $past(rst))
        else $error("remote wake dropped early");
    a_phy_by_write: assert property ($changed(phy_reset_out) |-> $rose(s_axi_bvalid) || $past(rst))
        else $error("phy reset moved alone");
    a_high_bits_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
        else $error("upper bits set");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    c_rwake: cover property (core_remote_wake_in);
    c_irq: cover property (!usb_wake_irq_n);
    c_phy: cover property (phy_reset_out);
endmodule // uswp_props

// *** dv/uswp_core_model.sv ***
module uswp_core_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic suspend_req,
    input wire logic resume_req,
    input wire logic [3:0] wake_delay,
    input wire logic core_remote_wake_in,
    output logic core_suspend_n = 1'h1
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // core suspend state, left on host resume or own remote wakeup
    always @(posedge clock) begin
        if (rst) begin
            core_suspend_n <= 1'h1;
        end else if (suspend_req) begin
            core_suspend_n <= 1'h0;
        end else if (!core_suspend_n && (resume_req || core_remote_wake_in)) begin
            repeat (wake_delay) @(posedge clock);
            core_suspend_n <= 1'h1;
        end
    end
endmodule // uswp_core_model

// *** dv/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'h0, rst = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0, wake_delay = 4'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, suspend_req = 1'h0, resume_req = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic core_suspend_n, core_remote_wake_in, phy_reset_out, usb_wake_irq_n;
    logic [33:0] q[$];
    int mismatches = 0, cmp_count = 0, cyc = 0;
    localparam logic [33:0] OK = {uswp_pkg::RESP_OKAY, 32'h0000_0000};
    localparam logic [33:0] DEC = {uswp_pkg::RESP_DECERR, 32'h0000_0000};

    uswp_power_ctl uswp_power_ctl_inst (
        .clock(clock),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .core_suspend_n(core_suspend_n),
        .core_remote_wake_in(core_remote_wake_in),
        .phy_reset_out(phy_reset_out),
        .usb_wake_irq_n(usb_wake_irq_n)
    );
    uswp_core_model uswp_core_model_inst (
        .clock(clock),
        .rst(rst),
        .suspend_req(suspend_req),
        .resume_req(resume_req),
        .wake_delay(wake_delay),
        .core_remote_wake_in(core_remote_wake_in),
        .core_suspend_n(core_suspend_n)
    );

    initial forever #2 clock = ~clock;

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [33:0] rv(input logic [3:0] f);
        return {uswp_pkg::RESP_OKAY, 24'h0000_00, f, 4'h0};
    endfunction

    // random upper bits must be ignored by the register
    function automatic logic [31:0] wd(input logic [7:0] b);
        logic [31:0] r;
        r = $urandom();
        return {r[31:8], b};
    endfunction

    // ==========
    // bus master: one write or one read, expected answer queued
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [33:0] e);
        logic ah, wh, done;
        q.push_back(e);
        ah = 1'h0;
        wh = !w;
        done = 1'h0;
        // one edge between transfers: no signal is assigned twice in one step
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        while (!done) begin
            @(negedge clock);
            ah = ah | (w ? s_axi_awready : s_axi_arready);
            wh = wh | s_axi_wready;
            done = w ? s_axi_bvalid : s_axi_rvalid;
            @(posedge clock);
            if (ah) begin
                s_axi_awvalid <= 1'h0;
                s_axi_arvalid <= 1'h0;
            end
            if (wh) s_axi_wvalid <= 1'h0;
            if (done) begin
                s_axi_bready <= 1'h0;
                s_axi_rready <= 1'h0;
            end
        end
    endtask

    task automatic pins(input logic [2:0] e);
        @(negedge clock);
        chk({31'h0000_0000, core_remote_wake_in, phy_reset_out, usb_wake_irq_n}, {31'h0000_0000, e});
        @(posedge clock);
    endtask

    always @(negedge clock) begin
        if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0000_0000}, q.pop_front());
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            summarize();
        end
    end

    // ==========
    // tests
    initial begin
        void'($urandom(91626));
        repeat (10) @(posedge clock);
        rst <= 1'h0;
        repeat (4) @(posedge clock);
        bus(1'h0, 8'h00, 32'h0000_0000, 4'h0, rv(4'h3));
        pins(3'h1);
        bus(1'h1, 8'h04, wd(8'hff), 4'hf, DEC);
        bus(1'h0, 8'h04, 32'h0000_0000, 4'h0, DEC);
        $display("reset test done");
        bus(1'h1, 8'h00, wd(8'h00), 4'hf, OK);
        pins(3'h3);
        repeat (20) @(posedge clock);
        pins(3'h3);
        bus(1'h0, 8'h00, 32'h0000_0000, 4'h0, rv(4'h1));
        bus(1'h1, 8'h00, wd(8'h20), 4'he, OK);
        pins(3'h3);
        bus(1'h1, 8'h00, wd(8'h20), 4'hf, OK);
        pins(3'h1);
        $display("phy reset test done");
        bus(1'h1, 8'h00, wd(8'h60), 4'hf, OK);
        pins(3'h1);
        bus(1'h0, 8'h00, 32'h0000_0000, 4'h0, rv(4'h3));
        suspend_req <= 1'h1;
        wake_delay <= 4'($urandom_range(1, 15));
        @(posedge clock);
        suspend_req <= 1'h0;
        repeat (4) @(posedge clock);
        bus(1'h0, 8'h00, 32'h0000_0000, 4'h0, rv(4'h2));
        bus(1'h1, 8'h00, wd(8'h60), 4'hf, OK);
        pins(3'h5);
        for (int i = 0; i < 40 && core_remote_wake_in; i++) @(posedge clock);
        pins(3'h1);
        bus(1'h0, 8'h00, 32'h0000_0000, 4'h0, rv(4'h3));
        $display("remote wake test done");
        bus(1'h1, 8'h00, wd(8'ha0), 4'hf, OK);
        pins(3'h0);
        suspend_req <= 1'h1;
        @(posedge clock);
        suspend_req <= 1'h0;
        resume_req <= 1'h1;
        pins(3'h1);
        resume_req <= 1'h0;
        for (int i = 0; i < 40 && !core_suspend_n; i++) @(posedge clock);
        pins(3'h0);
        bus(1'h1, 8'h00, wd(8'h20), 4'hf, OK);
        pins(3'h1);
        $display("wake output test done");
        summarize();
    end
endmodule // testbench

bind uswp_power_ctl uswp_props uswp_props_inst (
    .clock(clock),
    .rst(rst),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .core_suspend_n(core_suspend_n),
    .core_remote_wake_in(core_remote_wake_in),
    .phy_reset_out(phy_reset_out),
    .usb_wake_irq_n(usb_wake_irq_n)
);
